/* verilog/gpb_pkg.sv */
// package of constants for the multi-port gpio bank
//
// Overview of operation
// RQ1: every bit has its own direction control
// RQ2: port 1 is eight bidirectional pins
// RQ3: port 3 is four bidirectional pins
// RQ4: port 12 is three bidirectional pins
// RQ5: port 12 pull-up only on bit 0
// RQ6: port 6 open-drain, never drives high
// RQ7: ports 0, 1, 3 have per-pin pull-ups
// RQ8: each pin can carry an alternate function
// RQ9: port 0 is two pins with latch
// RQ10: reset forces every bit to input
// RQ11: port 12 upper bits are I/O unless oscillator mode
// RQ12: read gives pin for input, latch for output
package gpb_pkg;

    // port widths
    localparam int P0_W  = 2;
    localparam int P1_W  = 8;
    localparam int P3_W  = 4;
    localparam int P6_W  = 2;
    localparam int P12_W = 3;

    // total pin count of the bank, in order p0, p1, p3, p6, p12
    localparam int NPIN = P0_W + P1_W + P3_W + P6_W + P12_W;

    // bit offsets of each port within the flat pin vector
    localparam int P0_LSB  = 0;
    localparam int P1_LSB  = P0_LSB + P0_W;
    localparam int P3_LSB  = P1_LSB + P1_W;
    localparam int P6_LSB  = P3_LSB + P3_W;
    localparam int P12_LSB = P6_LSB + P6_W;

    // reset values
    localparam logic [NPIN-1:0] MODE_RST  = {NPIN{1'b1}}; // 1 = input
    localparam logic [NPIN-1:0] LATCH_RST = {NPIN{1'b0}};
    localparam logic [NPIN-1:0] PU_RST    = {NPIN{1'b0}};
    localparam logic [7:0]      CLKMODE_RST = 8'h00;

    // pins able to drive high; port 6 is open-drain
    localparam logic [NPIN-1:0] DRIVE_HIGH_OK =
        ~({{P12_W{1'b0}}, {P6_W{1'b1}}, {P3_W{1'b0}}, {P1_W{1'b0}}, {P0_W{1'b0}}});

    // pins that have a pull-up: ports 0, 1, 3 and port 12 bit 0
    localparam logic [NPIN-1:0] PULLUP_OK =
        {3'b001, {P6_W{1'b0}}, {P3_W{1'b1}}, {P1_W{1'b1}}, {P0_W{1'b1}}};

    // port 12 bits handed to the oscillator when selected
    localparam int OSC_IN_BIT  = P12_LSB + 1;
    localparam int OSC_OUT_BIT = P12_LSB + 2;

    // write select codes of the bank's register port
    typedef enum logic [1:0] {
        GPB_SEL_LATCH = 2'h0,
        GPB_SEL_MODE  = 2'h1,
        GPB_SEL_PU    = 2'h2,
        GPB_SEL_CLK   = 2'h3
    } gpb_sel_t;

endpackage

/* verilog/gpb_pin.sv */
// one pin slice: direction, drive, pull-up, alternate function and read mux
module gpb_pin
    import gpb_pkg::*;
#(
    parameter bit HIGH_OK = 1'b1,
    parameter bit PU_OK   = 1'b1
)(
    input  wire logic mode_i,
    input  wire logic latch_i,
    input  wire logic pu_i,
    input  wire logic alt_en_i,
    input  wire logic alt_out_i,
    input  wire logic alt_oe_i,
    input  wire logic pin_i,
    output logic      pin_o,
    output logic      pin_oe_n_o,
    output logic      pu_en_o,
    output logic      rd_o
);
    logic drive;
    logic val;

    always_comb
    begin
        // alternate function takes the pin when selected
        drive = alt_en_i ? alt_oe_i : ~mode_i;          // see RQ8 see RQ1
        val   = alt_en_i ? alt_out_i : latch_i;
        if (HIGH_OK)
        begin
            pin_o      = val;
            pin_oe_n_o = ~drive;
        end
        else
        begin
            // open drain: only pull low, release otherwise
            pin_o      = 1'b0;                          // see RQ6
            pin_oe_n_o = ~(drive & ~val);               // see RQ6
        end
        // pull-up acts only while the pin is not driven
        pu_en_o = PU_OK & pu_i & ~drive;                // see RQ7 see RQ5
        rd_o    = mode_i ? pin_i : latch_i;             // see RQ12
    end
endmodule // gpb_pin

/* verilog/gpb_bank.sv */
// top of the multi-port gpio bank
module gpb_bank
    import gpb_pkg::*;
(
    input  wire logic            CLK_I,
    input  wire logic            RESET_I,
    input  wire logic            CE_I,
    input  wire logic            WR_I,
    input  wire logic [1:0]      WR_SEL_I,
    input  wire logic [NPIN-1:0] WR_DATA_I,
    input  wire logic [NPIN-1:0] WR_MASK_I,
    input  wire logic [7:0]      CLK_MODE_I,
    input  wire logic            CLK_MODE_WR_I,
    input  wire logic [NPIN-1:0] ALT_EN_I,
    input  wire logic [NPIN-1:0] ALT_OUT_I,
    input  wire logic [NPIN-1:0] ALT_OE_I,
    input  wire logic [NPIN-1:0] PIN_I,
    output logic      [NPIN-1:0] PIN_O,
    output logic      [NPIN-1:0] PIN_OE_N_O,
    output logic      [NPIN-1:0] PULLUP_EN_O,
    output logic      [NPIN-1:0] RD_DATA_O,
    output logic      [NPIN-1:0] PIN_SYNC_O,
    output logic      [7:0]      CLK_MODE_O,
    output logic                 OSC_SEL_O
);
    ////////////////////////////////////////////////////////////////////////////
    // control registers
    logic [NPIN-1:0] mode_reg,  mode_next;
    logic [NPIN-1:0] latch_reg, latch_next;
    logic [NPIN-1:0] pu_reg,    pu_next;
    logic [7:0]      clk_reg,   clk_next;

    always_comb
    begin
        mode_next  = mode_reg;
        latch_next = latch_reg;
        pu_next    = pu_reg;
        clk_next   = clk_reg;
        if (WR_I)
        begin
            unique case (gpb_sel_t'(WR_SEL_I))
                GPB_SEL_LATCH: latch_next = (latch_reg & ~WR_MASK_I) | (WR_DATA_I & WR_MASK_I);
                GPB_SEL_MODE:  mode_next  = (mode_reg & ~WR_MASK_I) | (WR_DATA_I & WR_MASK_I); // see RQ1
                GPB_SEL_PU:    pu_next    = ((pu_reg & ~WR_MASK_I) | (WR_DATA_I & WR_MASK_I))
                                            & PULLUP_OK;                                      // see RQ5 see RQ7
                GPB_SEL_CLK:   clk_next   = clk_reg;
            endcase
        end
        if (CLK_MODE_WR_I)
            clk_next = CLK_MODE_I;
    end

    always_ff @(posedge CLK_I)
    begin
        if (RESET_I)
        begin
            mode_reg  <= MODE_RST;                     // see RQ10
            latch_reg <= LATCH_RST;                    // see RQ9
            pu_reg    <= PU_RST;
            clk_reg   <= CLKMODE_RST;                  // see RQ11
        end
        else if (CE_I)
        begin
            mode_reg  <= mode_next;
            latch_reg <= latch_next;
            pu_reg    <= pu_next;
            clk_reg   <= clk_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // per pin logic
    logic [NPIN-1:0] pin_w, oe_n_w, pu_w, rd_w, alt_en_w;
    logic            osc_sel;

    // nonzero clock mode hands port 12 upper bits to the oscillator
    assign osc_sel = (clk_reg != CLKMODE_RST);         // see RQ11

    always_comb
    begin
        alt_en_w = ALT_EN_I;
        if (osc_sel)
        begin
            alt_en_w[OSC_IN_BIT]  = 1'b1;              // see RQ11
            alt_en_w[OSC_OUT_BIT] = 1'b1;
        end
    end

    // see RQ2 see RQ3 see RQ4 see RQ9
    genvar g;
    generate
        for (g = 0; g < NPIN; g++)
        begin : g_pin
            gpb_pin #(
                .HIGH_OK (DRIVE_HIGH_OK[g]),
                .PU_OK   (PULLUP_OK[g])
            ) u_pin (
                .mode_i     (mode_reg[g]),
                .latch_i    (latch_reg[g]),
                .pu_i       (pu_reg[g]),
                .alt_en_i   (alt_en_w[g]),
                .alt_out_i  (ALT_OUT_I[g]),
                .alt_oe_i   (ALT_OE_I[g] & ~(osc_sel && g == OSC_IN_BIT)),
                .pin_i      (PIN_I[g]),
                .pin_o      (pin_w[g]),
                .pin_oe_n_o (oe_n_w[g]),
                .pu_en_o    (pu_w[g]),
                .rd_o       (rd_w[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // registered outputs
    always_ff @(posedge CLK_I)
    begin
        if (RESET_I)
        begin
            PIN_O       <= {NPIN{1'b0}};
            PIN_OE_N_O  <= {NPIN{1'b1}};
            PULLUP_EN_O <= {NPIN{1'b0}};
            RD_DATA_O   <= {NPIN{1'b0}};
            PIN_SYNC_O  <= {NPIN{1'b0}};
            CLK_MODE_O  <= CLKMODE_RST;
            OSC_SEL_O   <= 1'b0;
        end
        else if (CE_I)
        begin
            PIN_O       <= pin_w;
            PIN_OE_N_O  <= oe_n_w;
            PULLUP_EN_O <= pu_w;
            RD_DATA_O   <= rd_w;                       // see RQ12
            PIN_SYNC_O  <= PIN_I;                      // see RQ8
            CLK_MODE_O  <= clk_reg;
            OSC_SEL_O   <= osc_sel;
        end
    end
endmodule // gpb_bank

/* tb/gpb_bank_checker.sv */
// port assertions of the gpio bank
module gpb_bank_checker
    import gpb_pkg::*;
(
    input wire logic            CLK_I,
    input wire logic            RESET_I,
    input wire logic            CE_I,
    input wire logic            WR_I,
    input wire logic [1:0]      WR_SEL_I,
    input wire logic [NPIN-1:0] WR_DATA_I,
    input wire logic [NPIN-1:0] WR_MASK_I,
    input wire logic            CLK_MODE_WR_I,
    input wire logic [NPIN-1:0] ALT_EN_I,
    input wire logic [NPIN-1:0] PIN_I,
    input wire logic [NPIN-1:0] PIN_O,
    input wire logic [NPIN-1:0] PIN_OE_N_O,
    input wire logic [NPIN-1:0] PULLUP_EN_O,
    input wire logic [NPIN-1:0] RD_DATA_O,
    input wire logic [7:0]      CLK_MODE_O,
    input wire logic            OSC_SEL_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RESET_I);
    a_p6_never_high:
    assert property (PIN_O[15:14] == 2'h0) else $error("p6 high");
    a_pullup_allowed:
    assert property ((PULLUP_EN_O & ~PULLUP_OK) == '0) else $error("bad pullup");
    a_pullup_off_drv:
    assert property ((PULLUP_EN_O & ~PIN_OE_N_O) == '0) else $error("pullup driven");
    a_mode_write_drives:
    assert property (CE_I && WR_I && !CLK_MODE_WR_I && WR_SEL_I == 2'h1 && WR_MASK_I[2]
        && !WR_DATA_I[2] ##1 CE_I && !ALT_EN_I[2] |=> !PIN_OE_N_O[2]) else $error("no drive");
    a_read_input:
    assert property (CE_I && ALT_EN_I[13:0] == 14'h0000
        |=> (RD_DATA_O[13:0] & PIN_OE_N_O[13:0]) == ($past(PIN_I[13:0]) & PIN_OE_N_O[13:0]))
        else $error("read pin");
    a_read_latch:
    assert property (CE_I && !ALT_EN_I[2]
        |=> PIN_OE_N_O[2] || RD_DATA_O[2] == PIN_O[2]) else $error("read latch");
    a_osc_follows:
    assert property ($rose(OSC_SEL_O) |-> CLK_MODE_O != 8'h00) else $error("osc sel");
    a_osc_in_released:
    assert property (OSC_SEL_O |-> PIN_OE_N_O[OSC_IN_BIT]) else $error("osc pin driven");
endmodule // gpb_bank_checker

bind gpb_bank gpb_bank_checker u_chk (.*);

/* tb/gpb_pin_model.sv */
// pin side: drivers, pull-ups and external sources
module gpb_pin_model
    import gpb_pkg::*;
(
    input  wire logic            clk_i,
    input  wire logic [NPIN-1:0] drv_i,
    input  wire logic [NPIN-1:0] oe_n_i,
    input  wire logic [NPIN-1:0] pu_i,
    input  wire logic [NPIN-1:0] ext_en_i,
    input  wire logic [NPIN-1:0] ext_val_i,
    output logic      [NPIN-1:0] level_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [NPIN-1:0] last_reg = '0;
    // floating pins without pull-up flip every cycle
    assign level_o = (~oe_n_i & drv_i) | (oe_n_i & ext_en_i & ext_val_i)
        | (oe_n_i & ~ext_en_i & (pu_i | ~last_reg));
    always_ff @(posedge clk_i)
        last_reg <= level_o;
endmodule // gpb_pin_model

/* tb/gpb_bank_tb_top.sv */
// testbench of the gpio bank
module gpb_bank_tb_top
    import gpb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [NPIN-1:0] LAT = 19'h5A5A5;
    logic clk = 1'b0, rst = 1'b1, wr = 1'b0, cwr = 1'b0, osc, ce = 1'b1;
    logic [1:0] sel = 2'h0;
    logic [7:0] cm = 8'h00;
    logic [NPIN-1:0] wd = '0, wm = '0, aen = '0, ao = '0, xen = '1, xv = ~LAT;
    logic [NPIN-1:0] pin, po, oen, pue, rd, psy;
    int n_mismatch = 0, n_compared = 0;
    always #2.5 clk = ~clk;
    gpb_bank uut (.CLK_I(clk), .RESET_I(rst), .CE_I(ce), .WR_I(wr), .WR_SEL_I(sel),
        .WR_DATA_I(wd), .WR_MASK_I(wm), .CLK_MODE_I(cm), .CLK_MODE_WR_I(cwr), .ALT_EN_I(aen),
        .ALT_OUT_I(ao), .ALT_OE_I(aen), .PIN_I(pin), .PIN_O(po), .PIN_OE_N_O(oen),
        .PULLUP_EN_O(pue), .RD_DATA_O(rd), .PIN_SYNC_O(psy), .CLK_MODE_O(), .OSC_SEL_O(osc));
    gpb_pin_model pm (.clk_i(clk), .drv_i(po), .oe_n_i(oen), .pu_i(pue), .ext_en_i(xen),
        .ext_val_i(xv), .level_o(pin));
    task automatic chk(input string nm, input logic [NPIN-1:0] seen, exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wrt(input logic [1:0] s, input logic [NPIN-1:0] d, m);
        @(negedge clk);
        {wr, sel, wd, wm} = {1'b1, s, d, m};
        @(negedge clk);
        wr = 1'b0;
        @(negedge clk);
    endtask
    task automatic cmw(input logic [7:0] v);
        @(negedge clk);
        {cwr, cm} = {1'b1, v};
        @(negedge clk);
        cwr = 1'b0;
        repeat (2) @(negedge clk);
    endtask
    task automatic t_dir;
        wrt(2'h0, LAT, '1);
        wrt(2'h1, '0, '1);
        chk("oe_n", oen, LAT & ~DRIVE_HIGH_OK);
        chk("pin_o", po, LAT & DRIVE_HIGH_OK);
        chk("rd", rd, LAT);
        wrt(2'h1, '1, 19'h00020);
        @(negedge clk);
        chk("oe_n1", oen, (LAT & ~DRIVE_HIGH_OK) | 19'h00020);
        chk("rd1", rd, LAT ^ 19'h00020);
    endtask
    task automatic t_pu;
        xen = '0;
        wrt(2'h1, '1, '1);
        wrt(2'h2, '1, '1);
        @(negedge clk);
        chk("pullup", pue, PULLUP_OK);
        chk("rd_pu", rd & PULLUP_OK, PULLUP_OK);
    endtask
    task automatic t_alt;
        {aen, ao} = {19'h7FFFF, LAT};
        repeat (2) @(negedge clk);
        chk("alt", po, LAT & DRIVE_HIGH_OK);
        chk("sync", psy & DRIVE_HIGH_OK, LAT & DRIVE_HIGH_OK);
        aen = '0;
    endtask
    task automatic t_osc;
        wrt(2'h1, '0, '1);
        chk("osc_off", oen & 19'h20000, 19'h00000);
        cmw(8'h01);
        chk("osc", NPIN'(osc), 19'h00001);
        chk("osc_on", oen & 19'h20000, 19'h20000);
        cmw(8'h00);
        chk("osc_back", oen & 19'h20000, 19'h00000);
    endtask
    task automatic t_ce;
        ce = 1'b0;
        wrt(2'h0, ~LAT, '1);
        chk("ce_frz", po, LAT & DRIVE_HIGH_OK);
        ce = 1'b1;
        wrt(2'h3, ~LAT, '1);
        @(negedge clk);
        chk("ce_lost", po, LAT & DRIVE_HIGH_OK);
        chk("sel3_oe", oen, LAT & ~DRIVE_HIGH_OK);
    endtask
    task automatic t_rst;
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        chk("rst_oe", oen, '1);
        chk("rst_po", po, '0);
        @(negedge clk);
        chk("rst_oe1", oen, '1);
        chk("rst_pu", pue, '0);
    endtask
    task automatic give_verdict;
        if (n_mismatch == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (10) @(negedge clk);
        rst = 1'b0;
        chk("reset_oe", oen, '1);
        t_dir;
        t_pu;
        t_alt;
        t_osc;
        t_ce;
        t_rst;
        give_verdict;
    end
    initial
    begin
        #2000;
        n_mismatch++;
        give_verdict;
    end
endmodule // gpb_bank_tb_top
